// ### rtl/ssq_pkg.sv
// scan sequencer package: register map, fields, states and carriers
package ssq_pkg;
	// -------------------------------------------------------------
	// geometry and memory
	// -------------------------------------------------------------
	localparam int N_CHAN = 16;
	localparam int N_BANK = 4;
	localparam int BANK_W = 4;
	localparam int CHAN_IW = 4;
	localparam int MEM_DEPTH = 500000;
	localparam int PTR_W = 19;
	localparam logic [PTR_W-1:0] MEM_LAST = 19'(MEM_DEPTH - 1);
	localparam logic [PTR_W-1:0] TRIG_MAX = 19'(500000);
	localparam int IVL_W = 29;
	localparam logic [IVL_W-1:0] IVL_MAX_MS = 29'(359999000);
	// -------------------------------------------------------------
	// timing
	// -------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int MS_TIME_NS = 1000000;
	localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
	// -------------------------------------------------------------
	// register offsets and fields
	// -------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CFG = 8'h04;
	localparam logic [7:0] REG_LIST = 8'h08;
	localparam logic [7:0] REG_IVL = 8'h0C;
	localparam logic [7:0] REG_TCNT = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_REMOVE = 8'h18;
	localparam logic [7:0] REG_FETCH = 8'h1C;
	localparam logic [7:0] REG_COUNT = 8'h20;
	localparam logic [7:0] REG_RELAY = 8'h24;
	localparam logic [7:0] REG_CUR = 8'h28;
	localparam logic [7:0] REG_DIR = 8'h2C;
	localparam logic [7:0] REG_STAMP = 8'h30;
	localparam int CTL_INIT = 0;
	localparam int CTL_ABORT = 1;
	localparam int CTL_BUSTRIG = 2;
	localparam int CTL_FRESET = 3;
	localparam int CTL_CONFMEAS = 4;
	localparam int CTL_CARDRST = 5;
	localparam int CFG_CONT = 2;
	localparam int CFG_TOTRST = 3;
	localparam logic [3:0] CFG_RESET = 4'h0;
	localparam logic [PTR_W-1:0] TCNT_RESET = 19'h00001;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// -------------------------------------------------------------
	// types
	// -------------------------------------------------------------
	typedef enum logic [1:0] {SRC_TIMER = 2'b00, SRC_EXT = 2'b01, SRC_BUS = 2'b10, SRC_ALARM = 2'b11} ssq_src_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_PREP = 3'b001, ST_BREAK = 3'b010, ST_WAIT = 3'b011,
		ST_CLOSE = 3'b100, ST_MEASURE_PATH = 3'b101, ST_NEXT = 3'b110, ST_FINISH = 3'b111
	} ssq_state_e;
	typedef struct packed {
		logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
		logic bready; logic arvalid; logic [7:0] araddr; logic rready;
	} ssq_axi_req_s;
	typedef struct packed {
		logic awready; logic wready; logic bvalid; logic [1:0] bresp;
		logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
	} ssq_axi_rsp_s;
	typedef struct packed {
		logic [3:0] aux_bus_relay_b; logic [3:0] aux_bus_relay_a;
		logic [3:0] sense_bus_relay; logic [3:0] measure_bus_relay; logic [15:0] chan;
	} ssq_relay_s;
	typedef struct packed {
		logic [31:0] stamp; logic [3:0] chan; logic [15:0] value;
	} ssq_entry_s;
endpackage : ssq_pkg

// ### rtl/ssq_scan_sequencer.sv
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// scan sequencer: register slave, trigger sources, relay control, reading memory
module ssq_scan_sequencer #(
	parameter int P_MS_CYCLES = ssq_pkg::MS_CYCLES
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	// register bus
	input wire ssq_pkg::ssq_axi_req_s i_axi,
	output ssq_pkg::ssq_axi_rsp_s o_axi,
	// meter handshake and trigger pins
	input wire logic i_measure_path_done,
	input wire logic [15:0] i_measure_path_value,
	input wire logic i_ext_trig_n,
	input wire logic i_alarm_trigger_source,
	// relay and channel controls
	output ssq_pkg::ssq_relay_s o_relay,
	output logic o_cur_relay,
	output logic [3:0] o_cur_chan,
	output logic o_measure_path_req,
	output logic [3:0] o_measure_path_chan,
	output logic [15:0] o_monitor_en,
	output logic [15:0] o_dig_dir,
	output logic [15:0] o_tot_clear
);
	import ssq_pkg::*;

	// -------------------------------------------------------------
	// declarations
	// -------------------------------------------------------------
	ssq_state_e state_reg;
	ssq_axi_rsp_s rsp_reg;
	ssq_relay_s relay_reg;
	ssq_entry_s mem [MEM_DEPTH];
	logic [1:0] ext_sync_reg, alm_sync_reg, done_sync_reg;
	logic ext_d_reg, alm_d_reg, ext_pend_reg, cur_valid_reg, ovf_reg, cur_relay_reg, measure_path_req_reg;
	logic [3:0] cfg_reg, cur_chan_reg;
	logic [15:0] list_reg, fw_reg, dir_reg, rem_reg, mon_reg, tot_reg;
	logic [IVL_W-1:0] ivl_reg, elapsed_reg;
	logic [PTR_W-1:0] tcnt_reg, left_reg, wr_ptr_reg, rd_ptr_reg, cnt_reg, fetch_reg;
	logic [31:0] stamp_reg, last_stamp_reg, ms_div_reg;
	logic [CHAN_IW-1:0] cur_reg;
	logic [N_BANK-1:0] bank_scan;
	logic [N_CHAN-1:0] bank_chan;
	logic [31:0] rd_val;
	logic wr_ok;

	// -------------------------------------------------------------
	// decode and shared terms
	// -------------------------------------------------------------
	function automatic logic [CHAN_IW-1:0] first_set(input logic [N_CHAN-1:0] v);
		logic [CHAN_IW-1:0] idx;
		idx = '0;
		for (int i = N_CHAN - 1; i >= 0; i--) begin
			if (v[i]) idx = CHAN_IW'(i);
		end
		return idx;
	endfunction : first_set

	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		return (p == MEM_LAST) ? '0 : p + 19'h00001;
	endfunction : ptr_inc

	wire busy = state_reg != ST_IDLE;
	wire wr_en = rsp_reg.awready;
	wire rd_en = rsp_reg.arready;
	wire full_word = &i_axi.wstrb;
	wire [7:0] wa = i_axi.awaddr;
	wire [7:0] ra = i_axi.araddr;
	wire [31:0] wd = i_axi.wdata;
	wire ctl_fire = wr_en & wr_ok & (wa == REG_CTRL);
	wire c_init = ctl_fire & wd[CTL_INIT] & ~busy;
	wire c_abort = ctl_fire & wd[CTL_ABORT] & busy;
	wire c_bustrig = ctl_fire & wd[CTL_BUSTRIG];
	wire c_freset = ctl_fire & wd[CTL_FRESET] & ~busy;
	wire c_conf = ctl_fire & wd[CTL_CONFMEAS] & ~busy;
	wire c_cardrst = ctl_fire & wd[CTL_CARDRST] & ~busy;
	wire ms_tick = ms_div_reg == 32'(P_MS_CYCLES - 1);
	wire ext_fall = ext_d_reg & ~ext_sync_reg[1];
	wire alm_rise = ~alm_d_reg & alm_sync_reg[1];
	wire done_s = done_sync_reg[1];
	wire any_fw = |(list_reg & fw_reg);
	wire [3:0] sense_lock = busy ? (any_fw ? 4'hF : bank_scan) : 4'h0;
	wire [3:0] measure_path_lock = busy ? bank_scan : 4'h0;
	wire [15:0] chan_lock = busy ? bank_chan : 16'h0000;
	wire [1:0] cur_bank = cur_reg[CHAN_IW-1 -: 2];
	wire ssq_relay_s wr_relay = ssq_relay_s'(wd);
	wire full = cnt_reg == 19'(MEM_DEPTH);
	wire push = (state_reg == ST_MEASURE_PATH) & done_s & measure_path_req_reg & ~c_abort;
	wire pop = rd_en & (ra == REG_REMOVE) & (cnt_reg != '0);
	wire fetch_ok = rd_en & (ra == REG_FETCH) & ~busy & (fetch_reg < cnt_reg);
	wire [PTR_W:0] f_sum = {1'b0, rd_ptr_reg} + {1'b0, fetch_reg};
	wire [PTR_W-1:0] f_idx = (f_sum >= 20'(MEM_DEPTH)) ? PTR_W'(f_sum - 20'(MEM_DEPTH)) : f_sum[PTR_W-1:0];
	wire ssq_entry_s rd_ent = mem[pop ? rd_ptr_reg : f_idx];
	wire tmr_due = elapsed_reg >= ivl_reg;
	wire sweep_fire = (state_reg == ST_WAIT) & (
		(ssq_src_e'(cfg_reg[1:0]) == SRC_TIMER) ? tmr_due :
		(ssq_src_e'(cfg_reg[1:0]) == SRC_EXT) ? (ext_pend_reg | ext_fall) :
		(ssq_src_e'(cfg_reg[1:0]) == SRC_BUS) ? c_bustrig : alm_rise);

	// one lock group per bank
	for (genvar b = 0; b < N_BANK; b++) begin : g_bank
		assign bank_scan[b] = |list_reg[b*BANK_W +: BANK_W];
		assign bank_chan[b*BANK_W +: BANK_W] = {BANK_W{bank_scan[b]}};
	end

	// write legality and read mux; unmapped or partial writes answer slverr
	always_comb begin
		wr_ok = full_word;
		if (wa == REG_CTRL || wa == REG_RELAY || wa == REG_CUR) begin
			wr_ok = full_word;
		end else if (wa == REG_CFG || wa == REG_LIST || wa == REG_DIR) begin
			wr_ok = full_word & ~busy;
		end else if (wa == REG_IVL) begin
			wr_ok = full_word & ~busy & (wd[IVL_W-1:0] <= IVL_MAX_MS) & (wd[31:IVL_W] == '0);
		end else if (wa == REG_TCNT) begin
			wr_ok = full_word & ~busy & (wd[31:PTR_W] == '0) & (wd[PTR_W-1:0] != '0)
				& (wd[PTR_W-1:0] <= TRIG_MAX);
		end else begin
			wr_ok = 1'b0;
		end
	end

	always_comb begin
		rd_val = '0;
		if (ra == REG_CFG) begin
			rd_val = {28'h0000000, cfg_reg};
		end else if (ra == REG_LIST) begin
			rd_val = {fw_reg, list_reg};
		end else if (ra == REG_IVL) begin
			rd_val = {3'h0, ivl_reg};
		end else if (ra == REG_TCNT) begin
			rd_val = {13'h0000, tcnt_reg};
		end else if (ra == REG_STATUS) begin
			rd_val = {25'h0000000, state_reg, 1'b0, ext_pend_reg, ovf_reg, busy};
		end else if (ra == REG_REMOVE || ra == REG_FETCH) begin
			rd_val = (pop | fetch_ok) ? {12'h000, rd_ent.chan, rd_ent.value} : 32'h00000000;
		end else if (ra == REG_COUNT) begin
			rd_val = {13'h0000, cnt_reg};
		end else if (ra == REG_RELAY) begin
			rd_val = relay_reg;
		end else if (ra == REG_CUR) begin
			rd_val = {27'h0000000, cur_chan_reg, cur_relay_reg};
		end else if (ra == REG_DIR) begin
			rd_val = {16'h0000, dir_reg};
		end else if (ra == REG_STAMP) begin
			rd_val = last_stamp_reg;
		end
	end

	wire rd_map = (ra <= REG_STAMP) & (ra[1:0] == 2'h0) & ~(ra == REG_CTRL);

	// -------------------------------------------------------------
	// bus slave: one write and one read in flight
	// -------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg.awready <= i_axi.awvalid & i_axi.wvalid & ~rsp_reg.awready & ~rsp_reg.bvalid;
			rsp_reg.wready <= i_axi.awvalid & i_axi.wvalid & ~rsp_reg.awready & ~rsp_reg.bvalid;
			rsp_reg.arready <= i_axi.arvalid & ~rsp_reg.arready & ~rsp_reg.rvalid;
			if (wr_en) begin
				rsp_reg.bvalid <= 1'b1;
				rsp_reg.bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (i_axi.bready) begin
				rsp_reg.bvalid <= 1'b0;
			end
			if (rd_en) begin
				rsp_reg.rvalid <= 1'b1;
				rsp_reg.rdata <= rd_val;
				rsp_reg.rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
			end else if (i_axi.rready) begin
				rsp_reg.rvalid <= 1'b0;
			end
		end
	end

	// -------------------------------------------------------------
	// pin synchronisers and millisecond base
	// -------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ext_sync_reg <= 2'h3;
			alm_sync_reg <= 2'h0;
			done_sync_reg <= 2'h0;
			ext_d_reg <= 1'b1;
			alm_d_reg <= 1'b0;
			ms_div_reg <= '0;
			stamp_reg <= '0;
		end else begin
			ext_sync_reg <= {ext_sync_reg[0], i_ext_trig_n};
			alm_sync_reg <= {alm_sync_reg[0], i_alarm_trigger_source};
			done_sync_reg <= {done_sync_reg[0], i_measure_path_done};
			ext_d_reg <= ext_sync_reg[1];
			alm_d_reg <= alm_sync_reg[1];
			ms_div_reg <= ms_tick ? '0 : ms_div_reg + 32'h00000001;
			if (c_init) stamp_reg <= '0;
			else if (ms_tick) stamp_reg <= stamp_reg + 32'h00000001;
		end
	end

	// -------------------------------------------------------------
	// configuration registers
	// -------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cfg_reg <= CFG_RESET;
			list_reg <= '0;
			fw_reg <= '0;
			ivl_reg <= '0;
			tcnt_reg <= TCNT_RESET;
			dir_reg <= '0;
		end else if (c_freset) begin
			cfg_reg <= CFG_RESET;
			list_reg <= '0;
			fw_reg <= '0;
			ivl_reg <= '0;
			tcnt_reg <= TCNT_RESET;
		end else if (c_conf) begin
			ivl_reg <= '0;
			tcnt_reg <= TCNT_RESET;
		end else if (c_init) begin
			dir_reg <= dir_reg & ~list_reg;
		end else if (c_cardrst) begin
			dir_reg <= '0;
		end else if (wr_en && wr_ok) begin
			if (wa == REG_CFG) cfg_reg <= wd[3:0];
			if (wa == REG_LIST) {fw_reg, list_reg} <= wd;
			if (wa == REG_IVL) ivl_reg <= wd[IVL_W-1:0];
			if (wa == REG_TCNT) tcnt_reg <= wd[PTR_W-1:0];
			if (wa == REG_DIR) dir_reg <= wd[15:0];
		end
	end

	// -------------------------------------------------------------
	// trigger bookkeeping
	// -------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ext_pend_reg <= 1'b0;
			elapsed_reg <= '0;
			left_reg <= '0;
		end else if (c_init) begin
			ext_pend_reg <= 1'b0;
			elapsed_reg <= IVL_MAX_MS; // first sweep starts at once
			left_reg <= tcnt_reg;
		end else begin
			// one early pulse waits, later ones fall away
			if (ext_fall && busy && (ext_pend_reg || !sweep_fire)) ext_pend_reg <= 1'b1;
			else if (sweep_fire) ext_pend_reg <= 1'b0;
			if (sweep_fire) elapsed_reg <= '0;
			else if (ms_tick && !tmr_due) elapsed_reg <= elapsed_reg + 29'h0000001;
			if (sweep_fire && !cfg_reg[CFG_CONT]) left_reg <= left_reg - 19'h00001;
		end
	end

	// -------------------------------------------------------------
	// sequencer, relays and channel outputs
	// -------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			state_reg <= ST_IDLE;
			relay_reg <= '0;
			cur_relay_reg <= 1'b0;
			cur_chan_reg <= '0;
			rem_reg <= '0;
			cur_reg <= '0;
			cur_valid_reg <= 1'b0;
			measure_path_req_reg <= 1'b0;
			mon_reg <= '0;
			tot_reg <= '0;
		end else begin
			tot_reg <= '0;
			if (wr_en && wr_ok && wa == REG_RELAY) begin
				relay_reg.chan <= (relay_reg.chan & chan_lock) | (wr_relay.chan & ~chan_lock);
				relay_reg.measure_bus_relay <= (relay_reg.measure_bus_relay & measure_path_lock)
					| (wr_relay.measure_bus_relay & ~measure_path_lock);
				relay_reg.sense_bus_relay <= (relay_reg.sense_bus_relay & sense_lock)
					| (wr_relay.sense_bus_relay & ~sense_lock);
				relay_reg.aux_bus_relay_a <= wr_relay.aux_bus_relay_a;
				relay_reg.aux_bus_relay_b <= wr_relay.aux_bus_relay_b;
			end
			if (wr_en && wr_ok && wa == REG_CUR && !busy) begin
				{cur_chan_reg, cur_relay_reg} <= wd[4:0];
			end
			if (c_abort) begin
				measure_path_req_reg <= 1'b0;
				if (state_reg == ST_BREAK) cur_relay_reg <= 1'b0;
				state_reg <= ST_FINISH;
			end else begin
				case (state_reg)
					ST_IDLE: begin
						if (c_init) begin
							mon_reg <= list_reg;
							cur_valid_reg <= 1'b0;
							state_reg <= ST_PREP;
						end
					end
					ST_PREP: begin
						relay_reg.chan <= relay_reg.chan & ~bank_chan;
						relay_reg.measure_bus_relay <= '0;
						relay_reg.sense_bus_relay <= relay_reg.sense_bus_relay & ~(any_fw ? 4'hF : bank_scan);
						// current channel is set to zero before the current relay breaks
						if (cur_relay_reg) cur_chan_reg <= '0;
						state_reg <= cur_relay_reg ? ST_BREAK : ST_WAIT;
					end
					ST_BREAK: begin
						cur_relay_reg <= 1'b0;
						state_reg <= ST_WAIT;
					end
					ST_WAIT: begin
						if (sweep_fire) begin
							rem_reg <= list_reg;
							state_reg <= ST_NEXT;
						end
					end
					ST_NEXT: begin
						if (rem_reg != '0) begin
							cur_reg <= first_set(rem_reg);
							rem_reg[first_set(rem_reg)] <= 1'b0;
							cur_valid_reg <= 1'b1;
							state_reg <= ST_CLOSE;
						end else if (!cfg_reg[CFG_CONT] && left_reg == '0) begin
							state_reg <= ST_FINISH;
						end else begin
							state_reg <= ST_WAIT;
						end
					end
					ST_CLOSE: begin
						// wait for the meter to drop its last done
						if (!done_s) begin
							relay_reg.chan[cur_reg] <= 1'b1;
							relay_reg.measure_bus_relay[cur_bank] <= 1'b1;
							if (fw_reg[cur_reg]) relay_reg.sense_bus_relay[cur_bank] <= 1'b1;
							measure_path_req_reg <= 1'b1;
							state_reg <= ST_MEASURE_PATH;
						end
					end
					ST_MEASURE_PATH: begin
						if (done_s) begin
							measure_path_req_reg <= 1'b0;
							relay_reg.chan[cur_reg] <= 1'b0;
							relay_reg.measure_bus_relay[cur_bank] <= 1'b0;
							if (fw_reg[cur_reg]) relay_reg.sense_bus_relay[cur_bank] <= 1'b0;
							if (cfg_reg[CFG_TOTRST]) tot_reg[cur_reg] <= 1'b1;
							state_reg <= ST_NEXT;
						end
					end
					default: begin
						if (cur_valid_reg) begin
							relay_reg.chan[cur_reg] <= 1'b0;
							relay_reg.measure_bus_relay[cur_bank] <= 1'b0;
							if (fw_reg[cur_reg]) relay_reg.sense_bus_relay[cur_bank] <= 1'b0;
						end
						mon_reg <= '0;
						state_reg <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// reading memory: ring with overwrite of the oldest
	// -------------------------------------------------------------
	// storage has no reset; only pointers define what is valid
	always_ff @(posedge i_clk_sys) begin
		if (push) mem[wr_ptr_reg] <= '{stamp: stamp_reg, chan: cur_reg, value: i_measure_path_value};
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg <= '0;
			fetch_reg <= '0;
			ovf_reg <= 1'b0;
			last_stamp_reg <= '0;
		end else if (c_init) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg <= '0;
			fetch_reg <= '0;
			ovf_reg <= 1'b0;
		end else begin
			if (pop | fetch_ok) last_stamp_reg <= rd_ent.stamp;
			if (fetch_ok) fetch_reg <= fetch_reg + 19'h00001;
			if (push) wr_ptr_reg <= ptr_inc(wr_ptr_reg);
			if (push && pop) begin
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
			end else if (push && full) begin
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
				ovf_reg <= 1'b1;
			end else if (push) begin
				cnt_reg <= cnt_reg + 19'h00001;
			end else if (pop) begin
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
				cnt_reg <= cnt_reg - 19'h00001;
			end
		end
	end

	// outputs straight from flops
	assign o_axi = rsp_reg;
	assign o_relay = relay_reg;
	assign o_cur_relay = cur_relay_reg;
	assign o_cur_chan = cur_chan_reg;
	assign o_measure_path_req = measure_path_req_reg;
	assign o_measure_path_chan = cur_reg;
	assign o_monitor_en = mon_reg;
	assign o_dig_dir = dir_reg;
	assign o_tot_clear = tot_reg;

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);

	sequence s_abort_end;
		state_reg == ST_FINISH ##1 state_reg == ST_IDLE;
	endsequence

	AST_LIST_ONLY: assert property (state_reg == ST_CLOSE |-> list_reg[cur_reg])
		else $error("unlisted channel visited");
	AST_OVF: assert property (push && full && !pop |=> ovf_reg && cnt_reg == $past(cnt_reg))
		else $error("overflow not handled");
	AST_INIT_CLEAR: assert property (c_init |=> cnt_reg == '0 && !ovf_reg && state_reg == ST_PREP)
		else $error("memory not cleared at start");
	AST_PREP_OPEN: assert property (state_reg == ST_PREP && !c_abort |=>
		relay_reg.measure_bus_relay == '0 && (relay_reg.chan & bank_chan) == '0)
		else $error("relays not opened at start");
	AST_AUX: assert property (busy && !(wr_en && wa == REG_RELAY) |=>
		$stable({relay_reg.aux_bus_relay_b, relay_reg.aux_bus_relay_a}))
		else $error("aux relays changed by sequencer");
	AST_REFUSE_CFG: assert property (busy && wr_en && wa == REG_CFG |=>
		$stable(cfg_reg) && rsp_reg.bresp == RESP_SLVERR)
		else $error("config changed during scan");
	AST_ABORT: assert property (c_abort |=> s_abort_end ##0 cnt_reg == $past(cnt_reg, 2))
		else $error("abort sequence wrong");
	AST_MON: assert property (state_reg == ST_WAIT |-> o_monitor_en == list_reg)
		else $error("monitor mask wrong");
	AST_IDLE_ONLY: assert property (ctl_fire && wd[CTL_INIT] && busy && !c_abort |=>
		state_reg != ST_PREP)
		else $error("initiate accepted while busy");
	AST_BREAK: assert property (state_reg == ST_PREP && cur_relay_reg && !c_abort |=>
		cur_chan_reg == '0 && cur_relay_reg ##1 !cur_relay_reg)
		else $error("current path not broken in order");

endmodule : ssq_scan_sequencer

// ### test/ssq_meter_model.sv
// meter model: answers each measurement request after a short wait
`timescale 1ns/1ps
module ssq_meter_model (
	// clock
	input wire logic i_clk_sys,
	// request from the sequencer
	input wire logic i_measure_path_req,
	input wire logic [3:0] i_measure_path_chan,
	// answer to the sequencer
	output logic o_measure_path_done = 1'b0,
	output logic [15:0] o_measure_path_value = 16'h0
);
	logic [2:0] wait_reg = 3'h0;
	// four-phase; value toggles while not valid so a stale read shows
	always @(posedge i_clk_sys) begin
		if (i_measure_path_req !== 1'b1) begin // unknown before reset counts as idle
			o_measure_path_done <= 1'b0;
			wait_reg <= 3'h5;
			o_measure_path_value <= ~o_measure_path_value;
		end else if (wait_reg != 3'h0) begin
			wait_reg <= wait_reg - 3'h1;
			o_measure_path_value <= ~o_measure_path_value;
		end else begin
			o_measure_path_done <= 1'b1;
			o_measure_path_value <= {12'hA5C, i_measure_path_chan};
		end
	end
endmodule : ssq_meter_model

// ### test/ssq_scan_sequencer_tb.sv
// testbench for the scan sequencer
`timescale 1ns/1ps
module ssq_scan_sequencer_tb;
	import ssq_pkg::*;
	logic i_clk_sys = 1'b0;
	logic i_rstn = 1'b0;
	ssq_axi_req_s rq = '0;
	ssq_axi_rsp_s rs;
	ssq_relay_s rly;
	logic req, done;
	logic ext_n = 1'b1;
	logic alarm = 1'b0;
	logic [3:0] mch;
	logic [15:0] mval, mon, dir, tot;
	logic [3:0] cur_ch;
	logic cur_rl;
	logic [31:0] d;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	// small ms count keeps the timer short
	ssq_scan_sequencer #(.P_MS_CYCLES(4)) i_ssq_scan_sequencer (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
		.i_axi(rq), .o_axi(rs), .i_measure_path_done(done), .i_measure_path_value(mval), .i_ext_trig_n(ext_n),
		.i_alarm_trigger_source(alarm), .o_relay(rly), .o_cur_relay(cur_rl), .o_cur_chan(cur_ch),
		.o_measure_path_req(req), .o_measure_path_chan(mch), .o_monitor_en(mon), .o_dig_dir(dir), .o_tot_clear(tot));
	ssq_meter_model i_ssq_meter_model (.i_clk_sys(i_clk_sys), .i_measure_path_req(req), .i_measure_path_chan(mch),
		.o_measure_path_done(done), .o_measure_path_value(mval));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// write: hold address and data until awready, bready until bvalid
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
		@(posedge i_clk_sys);
		rq.awaddr <= a;
		rq.wdata <= v;
		rq.wstrb <= 4'hF;
		rq.awvalid <= 1'b1;
		rq.wvalid <= 1'b1;
		rq.bready <= 1'b1;
		do @(posedge i_clk_sys); while (rs.awready !== 1'b1);
		rq.awvalid <= 1'b0;
		rq.wvalid <= 1'b0;
		do @(posedge i_clk_sys); while (rs.bvalid !== 1'b1);
		rq.bready <= 1'b0;
		chk("bresp", {30'h0, e}, {30'h0, rs.bresp});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [1:0] e);
		@(posedge i_clk_sys);
		rq.araddr <= a;
		rq.arvalid <= 1'b1;
		rq.rready <= 1'b1;
		do @(posedge i_clk_sys); while (rs.arready !== 1'b1);
		rq.arvalid <= 1'b0;
		do @(posedge i_clk_sys); while (rs.rvalid !== 1'b1);
		rq.rready <= 1'b0;
		d = rs.rdata;
		chk("rresp", {30'h0, e}, {30'h0, rs.rresp});
	endtask : rd
	task automatic rv(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a, RESP_OKAY);
		chk(n, e, d);
	endtask : rv
	// poll busy; the watchdog bounds it
	task automatic wait_idle;
		do rd(REG_STATUS, RESP_OKAY); while (d[0] !== 1'b0);
	endtask : wait_idle
	task automatic t_limits;
		rv("tcnt", REG_TCNT, 32'h1);
		rv("ivl", REG_IVL, 32'h0);
		rd(8'h40, RESP_SLVERR);
		wr(REG_IVL, 32'(IVL_MAX_MS), RESP_OKAY);
		rv("ivl", REG_IVL, 32'(IVL_MAX_MS));
		wr(REG_IVL, 32'(IVL_MAX_MS) + 32'h1, RESP_SLVERR);
		wr(REG_TCNT, 32'h0, RESP_SLVERR);
		wr(REG_TCNT, 32'(TRIG_MAX) + 32'h1, RESP_SLVERR);
		wr(REG_TCNT, 32'(TRIG_MAX), RESP_OKAY);
		wr(REG_CTRL, 32'h10, RESP_OKAY);
		rv("ivl", REG_IVL, 32'h0);
		rv("tcnt", REG_TCNT, 32'h1);
		$display("limits done");
	endtask : t_limits
	// channels 0 and 2 listed, one bus trigger
	task automatic t_bus_scan;
		wr(REG_CFG, 32'h2, RESP_OKAY);
		wr(REG_LIST, 32'h5, RESP_OKAY);
		wr(REG_CTRL, 32'h1, RESP_OKAY);
		wr(REG_LIST, 32'h7, RESP_SLVERR);
		wr(REG_CFG, 32'h0, RESP_SLVERR);
		chk("monitor", 32'h5, {16'h0, mon});
		wr(REG_CTRL, 32'h4, RESP_OKAY);
		wait_idle();
		chk("relay", 32'h0, rly);
		rv("count", REG_COUNT, 32'h2);
		rv("fetch", REG_FETCH, 32'h0000A5C0);
		rv("count", REG_COUNT, 32'h2);
		rv("remove", REG_REMOVE, 32'h0000A5C0);
		rv("count", REG_COUNT, 32'h1);
		$display("bus scan done");
	endtask : t_bus_scan
	// new scan clears the leftover, abort returns to idle
	task automatic t_abort;
		wr(REG_CTRL, 32'h1, RESP_OKAY);
		rv("count", REG_COUNT, 32'h0);
		wr(REG_CTRL, 32'h2, RESP_OKAY);
		wait_idle();
		rv("count", REG_COUNT, 32'h0);
		$display("abort done");
	endtask : t_abort
	// four-wire channel 4 by timer, two sweeps back to back, current path broken first
	task automatic t_timer;
		wr(REG_DIR, 32'hFF, RESP_OKAY);
		wr(REG_CFG, 32'h8, RESP_OKAY);
		wr(REG_TCNT, 32'h2, RESP_OKAY);
		wr(REG_LIST, 32'h00100010, RESP_OKAY);
		wr(REG_CUR, 32'h1F, RESP_OKAY);
		chk("cur", 32'h1F, {27'h0, cur_ch, cur_rl});
		wr(REG_CTRL, 32'h1, RESP_OKAY);
		chk("dir", 32'hEF, {16'h0, dir});
		wait (req === 1'b1);
		@(posedge i_clk_sys);
		chk("closed", 32'h00220010, rly);
		chk("cur", 32'h0, {27'h0, cur_ch, cur_rl});
		do @(posedge i_clk_sys); while (req === 1'b1);
		chk("tot", 32'h10, {16'h0, tot});
		wait_idle();
		rv("count", REG_COUNT, 32'h2);
		chk("relay", 32'h0, rly);
		$display("timer done");
	endtask : t_timer
	// low-going pulse held three clocks, then three clocks high
	task automatic ext_pulse;
		ext_n <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
		ext_n <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
	endtask : ext_pulse
	// two pulses inside one sweep: the first waits, the second falls away
	task automatic t_ext;
		wr(REG_CFG, 32'h1, RESP_OKAY);
		wr(REG_TCNT, 32'h3, RESP_OKAY);
		wr(REG_LIST, 32'hF, RESP_OKAY);
		wr(REG_CTRL, 32'h1, RESP_OKAY);
		ext_pulse();
		wait (req === 1'b1);
		ext_pulse();
		ext_pulse();
		repeat (200) @(posedge i_clk_sys);
		rv("count", REG_COUNT, 32'h8);
		rv("status", REG_STATUS, 32'h31);
		wr(REG_RELAY, 32'hFFFFFFFF, RESP_OKAY);
		chk("relay", 32'hFFEEFFF0, rly);
		wr(REG_CTRL, 32'h20, RESP_OKAY);
		chk("dir", 32'hE0, {16'h0, dir});
		wr(REG_CTRL, 32'h2, RESP_OKAY);
		wait_idle();
		rv("count", REG_COUNT, 32'h8);
		$display("external done");
	endtask : t_ext
	// alarm edge starts one sweep; factory reset empties the list
	task automatic t_alarm;
		wr(REG_RELAY, 32'h0, RESP_OKAY);
		wr(REG_CFG, 32'h3, RESP_OKAY);
		wr(REG_TCNT, 32'h1, RESP_OKAY);
		wr(REG_LIST, 32'h100, RESP_OKAY);
		wr(REG_CTRL, 32'h1, RESP_OKAY);
		alarm <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
		alarm <= 1'b0;
		wait_idle();
		rv("remove", REG_REMOVE, 32'h0008A5C8);
		wr(REG_CTRL, 32'h8, RESP_OKAY);
		rv("list", REG_LIST, 32'h0);
		wr(REG_CTRL, 32'h20, RESP_OKAY);
		chk("dir", 32'h0, {16'h0, dir});
		$display("alarm done");
	endtask : t_alarm
	task automatic print_verdict;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict
	initial begin
		forever #20 i_clk_sys = ~i_clk_sys;
	end
	// watchdog: far above the few hundred cycles the tests take
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			print_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		t_limits();
		t_bus_scan();
		t_abort();
		t_timer();
		t_ext();
		t_alarm();
		print_verdict();
	end
endmodule : ssq_scan_sequencer_tb
